// *** inc/mbrtu_pkg.sv ***
// Constants, types and CRC step for the RTU slave framer
// Functional notes
// - Multi-byte numbers travel most significant byte first, CRC excepted.
// - A normal reply echoes the query's function code unchanged.
// - Character: start bit, eight data bits LSB first, optional even/odd parity.
// - One stop bit with parity, two stop bits without parity.
// - Frame starts after at least 3.5 idle character times; first byte is address.
// - At least 3.5 idle character times end a frame before another starts.
// - Transmitter sends a frame's characters back to back without gaps.
// - Idle above 1.5 characters mid-frame flushes it; next byte is new address.
// - Bytes closer than 3.5 characters join the previous frame, failing its CRC; here only bytes within 1.5 characters join it.
// - Addresses 0-247 valid, slave owns 1-247, address 0 is broadcast.
// - Never reply to a broadcast frame.
// - Function codes are 1-127, so query function bit 7 is zero.
// - Error reply sets function bit 7 and carries an exception code.
// - Data addresses inside messages are zero-based.
// - The 16-bit check value ends the frame, low byte first.
// - Check covers whole frame; receiver recomputes and flags any mismatch; here only in own or broadcast frames with no parity or stop error.
// - CRC register presets to all ones; each data byte XORs into it.
// - Eight right shifts per byte, XOR A001 when a one drops out.
// - Byte count equals data bytes following it, excluding other fields.
// - Register read reply: address, function, count, registers hi-lo ascending, CRC.
// - Queries with parity or CRC error are dropped silently without reply.
// - Exception codes: 01 bad function, 02 bad address, 03 bad value.
package mbrtu_pkg;
    localparam int          CLK_HZ       = 40_000_000;
    localparam int          BAUD_DEF     = 19200;
    localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / BAUD_DEF);
    // Idle thresholds in half bit times for 11-bit characters
    localparam logic [23:0] T15_HALF     = 24'h000021;
    localparam logic [23:0] T35_HALF     = 24'h00004D;
    localparam logic [3:0]  LAST_BIT     = 4'hA;
    localparam logic [7:0]  ADDR_BCAST   = 8'h00;
    localparam logic [7:0]  ADDR_MAX     = 8'hF7;
    localparam logic [7:0]  FUNC_EXC_BIT = 8'h80;
    localparam logic [7:0]  EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0]  EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0]  EXC_ILL_VAL  = 8'h03;
    localparam logic [15:0] CRC_INIT     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'hA001;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_BAUD     = 8'h04;
    localparam logic [7:0]  REG_STATUS   = 8'h08;
    localparam logic [7:0]  REG_RXDATA   = 8'h0C;
    localparam logic [7:0]  REG_QFIELD   = 8'h10;
    localparam logic [7:0]  REG_QHEAD    = 8'h14;
    localparam logic [7:0]  REG_TXDATA   = 8'h18;
    localparam logic [7:0]  REG_TXCTRL   = 8'h1C;
    localparam int          CTRL_EN      = 0;
    localparam int          CTRL_PAR     = 1;
    localparam int          CTRL_ADDR    = 8;
    localparam logic [31:0] CTRL_RST     = 32'h00000100;
    localparam int          ST_READY     = 0;
    localparam int          ST_CRC       = 1;
    localparam int          ST_PAR       = 2;
    localparam int          ST_BCAST     = 3;
    localparam int          ST_FUNC      = 4;
    localparam int          TXC_GO       = 0;
    localparam int          TXC_EXC      = 1;
    localparam int          TXC_BC       = 2;
    localparam int          TXC_CLR      = 3;
    localparam int          TXC_CODE     = 8;
    localparam int          TXD_BYTE     = 16;
    localparam logic [1:0]  PAR_NONE     = 2'h0;
    localparam logic [1:0]  PAR_ODD      = 2'h2;

    typedef struct packed {
        logic       en;
        logic [1:0] par;
        logic [7:0] addr;
    } cfg_s;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef enum logic [2:0] {
        R_IDLE  = 3'h0,
        R_START = 3'h1,
        R_DATA  = 3'h3,
        R_PAR   = 3'h2,
        R_STOP  = 3'h6
    } rx_st_e;

    typedef enum logic [1:0] {
        T_IDLE = 2'h0,
        T_WAIT = 2'h1,
        T_SEND = 2'h3
    } tx_st_e;

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {8'h00, d};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction
endpackage

// *** logic/mbrtu_slave_framer.sv ***
// RTU slave framer: serial receive, frame delimiting, filtering, reply build
`timescale 1ns/100ps
module mbrtu_slave_framer #(
    parameter int BUF_DEPTH = 256
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RST_N,
    input  wire logic                CE,
    input  wire mbrtu_pkg::apb_req_s APB_REQ,
    output logic [31:0]              PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                RXD,
    output logic                     TXD,
    output logic                     TX_EN
);
    import mbrtu_pkg::*;
    localparam int IW = $clog2(BUF_DEPTH) + 1;
    localparam logic [IW-1:0] DEPTH = IW'(BUF_DEPTH);

    cfg_s          cfg_reg;
    logic [15:0]   div_reg;
    logic          pready_reg, pslverr_reg;
    logic [31:0]   prdata_reg;
    logic [2:0]    sync_reg;
    logic          rxl_reg;
    rx_st_e        rst_reg;
    logic [15:0]   rbaud_reg;
    logic [2:0]    rbit_reg;
    logic [7:0]    rsh_reg;
    logic          rperr_reg, bv_reg, berr_reg;
    logic [23:0]   icnt_reg;
    logic          inf_reg, closed_reg, fbad_reg;
    logic [IW-1:0] widx_reg, rrd_reg, qlen_reg;
    logic [15:0]   rcrc_reg;
    logic [7:0]    rxbuf [BUF_DEPTH];
    logic [7:0]    cap_addr, cap_func, qaddr_reg, qfunc_reg;
    logic [31:0]   cap_field, qfield_reg;
    logic [4:0]    st_reg;
    logic          rok_reg;
    logic [7:0]    txbuf [BUF_DEPTH];
    logic [IW-1:0] twr_reg, tpos_reg;
    tx_st_e        tst_reg;
    logic          texc_reg, tbc_reg, ten_reg;
    logic [7:0]    tcode_reg;
    logic [15:0]   tbaud_reg, tcrc_reg;
    logic [3:0]    tbit_reg;
    logic [10:0]   tsh_reg;

    // APB decode
    wire        acc   = APB_REQ.psel & APB_REQ.penable;
    wire        done  = acc & pready_reg;
    wire        wr    = done & APB_REQ.pwrite;
    wire        rd    = done & ~APB_REQ.pwrite;
    wire [7:0]  pa    = APB_REQ.paddr;
    wire [31:0] wd    = APB_REQ.pwdata;
    wire a_ctrl = pa == REG_CTRL;
    wire a_baud = pa == REG_BAUD;
    wire a_stat = pa == REG_STATUS;
    wire a_rxd  = pa == REG_RXDATA;
    wire a_qf   = pa == REG_QFIELD;
    wire a_qh   = pa == REG_QHEAD;
    wire a_txd  = pa == REG_TXDATA;
    wire a_txc  = pa == REG_TXCTRL;
    wire mapped = a_ctrl | a_baud | a_stat | a_rxd | a_qf | a_qh | a_txd | a_txc;
    wire [7:0]  rx_rd_byte = (rrd_reg < DEPTH) ? rxbuf[rrd_reg[IW-2:0]] : 8'h00;
    wire [31:0] stat_val = {24'h000000, rok_reg, tst_reg != T_IDLE, 1'b0, st_reg};
    wire [31:0] rd_val =
        a_ctrl ? {16'h0000, cfg_reg.addr, 5'h00, cfg_reg.par, cfg_reg.en} :
        a_baud ? {16'h0000, div_reg} :
        a_stat ? stat_val :
        a_rxd  ? {24'h000000, rx_rd_byte} :
        a_qf   ? qfield_reg :
        a_qh   ? {{(16-IW){1'b0}}, qlen_reg, qfunc_reg, qaddr_reg} :
        a_txd  ? {{(32-IW){1'b0}}, twr_reg} : 32'h00000000;

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h00000000;
        end else if (CE) begin
            // Error flag stands only in the ready cycle
            pready_reg  <= acc & ~pready_reg;
            pslverr_reg <= acc & ~pready_reg & ~mapped;
            if (acc & ~pready_reg) begin
                prdata_reg <= mapped ? rd_val : 32'h00000000;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_reg.en   <= CTRL_RST[CTRL_EN];
            cfg_reg.par  <= CTRL_RST[CTRL_PAR+1:CTRL_PAR];
            cfg_reg.addr <= CTRL_RST[CTRL_ADDR+7:CTRL_ADDR];
            div_reg <= BAUD_DIV_RST;
        end else if (CE) begin
            if (wr & a_ctrl) begin
                cfg_reg.en   <= wd[CTRL_EN];
                cfg_reg.par  <= wd[CTRL_PAR+1:CTRL_PAR];
                cfg_reg.addr <= wd[CTRL_ADDR+7:CTRL_ADDR];
            end
            if (wr & a_baud) begin
                div_reg <= wd[15:0];
            end
        end
    end

    // Receiver: three-stage synchroniser, change taken once stages 2 and 3 agree
    wire r_half = rbaud_reg == {1'b0, div_reg[15:1]};
    wire r_full = rbaud_reg == div_reg - 16'h0001;
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            sync_reg <= 3'h7;
            rxl_reg  <= 1'b1;
        end else if (CE) begin
            sync_reg <= {sync_reg[1:0], RXD};
            if (sync_reg[1] == sync_reg[2]) begin
                rxl_reg <= sync_reg[2];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_reg   <= R_IDLE;
            rbaud_reg <= 16'h0000;
            rbit_reg  <= 3'h0;
            rsh_reg   <= 8'h00;
            rperr_reg <= 1'b0;
            bv_reg    <= 1'b0;
            berr_reg  <= 1'b0;
        end else if (CE) begin
            bv_reg    <= 1'b0;
            rbaud_reg <= (r_full || rst_reg == R_IDLE) ? 16'h0000 : rbaud_reg + 16'h0001;
            case (rst_reg)
                R_IDLE: begin
                    rperr_reg <= 1'b0;
                    if (!rxl_reg && cfg_reg.en) begin
                        rst_reg <= R_START;
                    end
                end
                R_START: begin
                    if (r_half) begin
                        rbaud_reg <= 16'h0000;
                        rbit_reg  <= 3'h0;
                        rst_reg   <= rxl_reg ? R_IDLE : R_DATA;
                    end
                end
                R_DATA: begin
                    if (r_full) begin
                        rsh_reg  <= {rxl_reg, rsh_reg[7:1]};
                        rbit_reg <= rbit_reg + 3'h1;
                        if (rbit_reg == 3'h7) begin
                            rst_reg <= (cfg_reg.par == PAR_NONE) ? R_STOP : R_PAR;
                        end
                    end
                end
                R_PAR: begin
                    if (r_full) begin
                        rperr_reg <= rxl_reg ^ (^rsh_reg) ^ (cfg_reg.par == PAR_ODD);
                        rst_reg   <= R_STOP;
                    end
                end
                default: begin
                    // First stop bit is checked; a second stop or mark parity idles
                    if (r_full) begin
                        bv_reg   <= 1'b1;
                        berr_reg <= rperr_reg | ~rxl_reg;
                        rst_reg  <= R_IDLE;
                    end
                end
            endcase
        end
    end

    // Line idle timing in system clocks
    wire [23:0] t15    = ({8'h00, div_reg} * T15_HALF) >> 1;
    wire [23:0] t35    = ({8'h00, div_reg} * T35_HALF) >> 1;
    wire        gap15  = icnt_reg > t15;
    wire        gap35  = icnt_reg >= t35;
    wire        newf   = bv_reg & (~inf_reg | closed_reg);
    wire [IW-1:0] bidx = newf ? '0 : widx_reg;
    wire        ovf    = bidx >= DEPTH;
    wire        f_end  = inf_reg & gap35 & ~bv_reg;
    wire        bcast  = cap_addr == ADDR_BCAST;
    wire        own    = (cap_addr == cfg_reg.addr) && !bcast && cap_addr <= ADDR_MAX;
    wire        crc_ok = (rcrc_reg == 16'h0000) && widx_reg >= IW'(4);
    wire        fn_bad = cap_func == 8'h00 || cap_func[7];
    wire        hit    = f_end & (own | bcast);
    wire        accept = hit & crc_ok & ~fbad_reg & ~fn_bad;
    wire [4:0]  st_set = {hit & crc_ok & ~fbad_reg & fn_bad, accept & bcast,
                          hit & fbad_reg, hit & ~crc_ok & ~fbad_reg, accept};
    wire [4:0]  st_clr = (wr & a_stat) ? wd[4:0] : 5'h00;
    // Go is refused unless a reply is owed and the sender is idle
    wire        go_ok  = wr & a_txc & wd[TXC_GO] & rok_reg & (tst_reg == T_IDLE);

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            icnt_reg <= 24'h000000;
        end else if (CE) begin
            if (rst_reg != R_IDLE || tst_reg == T_SEND) begin
                icnt_reg <= 24'h000000;
            end else if (icnt_reg != 24'hFFFFFF) begin
                icnt_reg <= icnt_reg + 24'h000001;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (CE && bv_reg && !ovf) begin
            rxbuf[bidx[IW-2:0]] <= rsh_reg;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            inf_reg    <= 1'b0;
            closed_reg <= 1'b0;
            fbad_reg   <= 1'b0;
            widx_reg   <= '0;
            rcrc_reg   <= CRC_INIT;
            cap_addr   <= 8'h00;
            cap_func   <= 8'h00;
            cap_field  <= 32'h00000000;
        end else if (CE) begin
            if (bv_reg) begin
                // Bytes inside the 1.5 gap append, so a late tail fails the CRC
                inf_reg    <= 1'b1;
                closed_reg <= 1'b0;
                widx_reg   <= ovf ? bidx : bidx + IW'(1);
                rcrc_reg   <= crc_byte(newf ? CRC_INIT : rcrc_reg, rsh_reg);
                fbad_reg   <= (~newf & fbad_reg) | berr_reg | ovf;
                if (bidx == '0) begin
                    cap_addr <= rsh_reg;
                end
                if (bidx == IW'(1)) begin
                    cap_func <= rsh_reg;
                end
                if (bidx >= IW'(2) && bidx <= IW'(5)) begin
                    cap_field <= {cap_field[23:0], rsh_reg};
                end
            end else if (f_end) begin
                inf_reg <= 1'b0;
            end else if (inf_reg && gap15) begin
                closed_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_reg     <= 5'h00;
            rok_reg    <= 1'b0;
            qaddr_reg  <= 8'h00;
            qfunc_reg  <= 8'h00;
            qfield_reg <= 32'h00000000;
            qlen_reg   <= '0;
            rrd_reg    <= '0;
        end else if (CE) begin
            // Sticky status: a set in the clear cycle wins
            st_reg <= st_set | (st_reg & ~st_clr);
            if (accept) begin
                rok_reg    <= ~bcast;
                qaddr_reg  <= cap_addr;
                qfunc_reg  <= cap_func;
                qfield_reg <= cap_field;
                qlen_reg   <= widx_reg;
            end else if (newf || go_ok) begin
                rok_reg <= 1'b0;
            end
            if (wr & a_rxd) begin
                rrd_reg <= '0;
            end else if (rd & a_rxd && rrd_reg < DEPTH) begin
                rrd_reg <= rrd_reg + IW'(1);
            end
        end
    end

    // Reply builder
    wire [IW-1:0] hdr    = (texc_reg | tbc_reg) ? IW'(3) : IW'(2);
    wire [IW-1:0] last   = hdr + (texc_reg ? '0 : twr_reg);
    wire [IW-1:0] didx   = tpos_reg - hdr;
    wire [7:0]    fn_out = texc_reg ? (qfunc_reg | FUNC_EXC_BIT) : qfunc_reg;
    wire [7:0]    tbyte  =
        (tpos_reg == '0)     ? qaddr_reg :
        (tpos_reg == IW'(1)) ? fn_out :
        (tpos_reg == IW'(2) && hdr == IW'(3)) ?
            (texc_reg ? tcode_reg : twr_reg[7:0]) :
        (tpos_reg < last)    ? txbuf[didx[IW-2:0]] :
        (tpos_reg == last)   ? tcrc_reg[7:0] : tcrc_reg[15:8];
    wire          tpar   = (cfg_reg.par == PAR_NONE) ? 1'b1 :
                           (^tbyte) ^ (cfg_reg.par == PAR_ODD);
    wire          t_tick = tbaud_reg == div_reg - 16'h0001;
    wire          t_end  = t_tick && tbit_reg == LAST_BIT;
    wire          more   = tpos_reg <= last + IW'(1);
    wire          load   = (tst_reg == T_WAIT && gap35) || (tst_reg == T_SEND && t_end && more);
    // Buffer writes refused while a reply runs or when they would overflow
    wire          tw_one = wd[TXD_BYTE];
    wire          tw_ok  = wr & a_txd & (tst_reg == T_IDLE) &
                           (twr_reg + (tw_one ? IW'(1) : IW'(2)) <= DEPTH);
    wire [IW-1:0] twr_p1 = twr_reg + IW'(1);

    always_ff @(posedge CORE_CLK) begin
        if (CE && tw_ok) begin
            if (tw_one) begin
                txbuf[twr_reg[IW-2:0]] <= wd[7:0];
            end else begin
                txbuf[twr_reg[IW-2:0]]            <= wd[15:8];
                txbuf[twr_p1[IW-2:0]]  <= wd[7:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            tst_reg   <= T_IDLE;
            twr_reg   <= '0;
            tpos_reg  <= '0;
            texc_reg  <= 1'b0;
            tbc_reg   <= 1'b0;
            tcode_reg <= EXC_ILL_FUNC;
            tcrc_reg  <= CRC_INIT;
            tbaud_reg <= 16'h0000;
            tbit_reg  <= 4'h0;
            tsh_reg   <= 11'h7FF;
            ten_reg   <= 1'b0;
        end else if (CE) begin
            if (tw_ok) begin
                twr_reg <= twr_reg + (tw_one ? IW'(1) : IW'(2));
            end else if (wr & a_txc & wd[TXC_CLR] & (tst_reg == T_IDLE)) begin
                twr_reg <= '0;
            end
            if (go_ok) begin
                tst_reg   <= T_WAIT;
                texc_reg  <= wd[TXC_EXC];
                tbc_reg   <= wd[TXC_BC];
                tcode_reg <= wd[TXC_CODE+7:TXC_CODE];
                tpos_reg  <= '0;
                tcrc_reg  <= CRC_INIT;
            end else if (load) begin
                tst_reg   <= T_SEND;
                tsh_reg   <= {1'b1, tpar, tbyte, 1'b0};
                tpos_reg  <= tpos_reg + IW'(1);
                tbaud_reg <= 16'h0000;
                tbit_reg  <= 4'h0;
                ten_reg   <= 1'b1;
                if (tpos_reg < last) begin
                    tcrc_reg <= crc_byte(tcrc_reg, tbyte);
                end
            end else if (tst_reg == T_SEND) begin
                tbaud_reg <= t_tick ? 16'h0000 : tbaud_reg + 16'h0001;
                if (t_tick) begin
                    tsh_reg  <= {1'b1, tsh_reg[10:1]};
                    tbit_reg <= tbit_reg + 4'h1;
                end
                // Next byte loads on the last stop edge, so no gap appears
                if (t_end) begin
                    tst_reg <= T_IDLE;
                    ten_reg <= 1'b0;
                    twr_reg <= '0;
                end
            end
        end
    end

    assign PRDATA  = prdata_reg;
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign TXD     = tsh_reg[0];
    assign TX_EN   = ten_reg;
endmodule

// *** verification/mbrtu_slave_framer_properties.sv ***
// Port checker for the RTU slave framer
`timescale 1ns/100ps
module mbrtu_slave_framer_properties #(
    parameter int BIT_CYC = 8
) (
    input  wire logic                CORE_CLK,
    input  wire logic                RST_N,
    input  wire logic                CE,
    input  wire mbrtu_pkg::apb_req_s APB_REQ,
    input  wire logic [31:0]         PRDATA,
    input  wire logic                PREADY,
    input  wire logic                PSLVERR,
    input  wire logic                RXD,
    input  wire logic                TXD,
    input  wire logic                TX_EN
);
    import mbrtu_pkg::*;
    localparam int HI_MAX = 10 * BIT_CYC + 2;
    localparam int Q_MIN  = 38 * BIT_CYC;
    logic [11:0] hi_cnt;
    logic [11:0] q_cnt;
    wire         acc = APB_REQ.psel && APB_REQ.penable;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // High run inside a reply; quiet time on both lines
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_cnt <= '0;
            q_cnt  <= '0;
        end else begin
            hi_cnt <= (TX_EN && TXD) ? hi_cnt + 12'h001 : 12'h000;
            q_cnt  <= (!RXD || TX_EN) ? 12'h000 : q_cnt + {11'h000, ~&q_cnt};
        end
    end
    txd_idle_a: assert property (!TX_EN |-> TXD)
        else $error("line low while driver off");
    start_bit_a: assert property ($rose(TX_EN) |-> !TXD)
        else $error("reply opens without start bit");
    stop_bit_a: assert property ($fell(TX_EN) |-> $past(TXD) && $past(TXD, BIT_CYC+1))
        else $error("reply ends without stop bits");
    tx_gap_a: assert property (hi_cnt <= HI_MAX)
        else $error("gap between reply characters");
    reply_quiet_a: assert property ($rose(TX_EN) |-> q_cnt >= Q_MIN)
        else $error("reply starts before line quiet");
    ready_lat_a: assert property (CE && $rose(acc) |=> PREADY)
        else $error("ready not one cycle after access");
    ready_once_a: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    slverr_ready_a: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
        else $error("error without ready or with data");
endmodule
bind mbrtu_slave_framer mbrtu_slave_framer_properties i_props (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CE(CE), .APB_REQ(APB_REQ), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD), .TXD(TXD), .TX_EN(TX_EN));

// *** verification/mbrtu_master_model.sv ***
// Serial master model: sends queries, collects reply bytes
`timescale 1ns/100ps
module mbrtu_master_model (
    input  wire logic        clk,
    input  wire logic [15:0] div,
    input  wire logic        line_in,
    output logic             line_out
);
    logic [7:0] rxq[$];
    logic       stop_bad = 1'b0;
    logic [7:0] sh;
    initial line_out = 1'b1;
    function automatic logic [15:0] crc16(input logic [7:0] m[$]);
        logic [15:0] c = 16'hFFFF;
        foreach (m[i]) begin
            c ^= {8'h00, m[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return c;
    endfunction
    task automatic bit_out(input logic v);
        line_out <= v;
        repeat (div) @(posedge clk);
    endtask
    // Mode 0 good check value, 1 corrupted, 2 none
    task automatic send(input logic [7:0] m[$], input int mode);
        logic [15:0] c = crc16(m) ^ {15'h0, mode == 1};
        if (mode != 2) m = {m, c[7:0], c[15:8]};
        foreach (m[i]) begin
            bit_out(1'b0);
            for (int b = 0; b < 8; b++) bit_out(m[i][b]);
            bit_out(1'b1);
            bit_out(1'b1);
        end
    endtask
    always @(negedge line_in) begin
        repeat (div / 2) @(posedge clk);
        for (int b = 0; b < 8; b++) begin
            repeat (div) @(posedge clk);
            sh[b] = line_in;
        end
        repeat (div) @(posedge clk);
        if (line_in !== 1'b1) stop_bad = 1'b1;
        rxq.push_back(sh);
    end
endmodule

// *** verification/mbrtu_slave_framer_test.sv ***
// Self-checking bench for the RTU slave framer
`timescale 1ns/100ps
module mbrtu_slave_framer_test;
    import mbrtu_pkg::*;
    typedef logic [7:0] bytes_t[$];
    typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} row_s;
    localparam int DIV  = 8;
    localparam int CHAR = 11 * DIV;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    apb_req_s    req = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxd;
    logic        txd;
    logic        tx_en;
    logic [31:0] rdata;
    logic        rerr;
    int          err_total = 0;
    int          checks = 0;
    bytes_t      q1 = '{8'h06, 8'h03, 8'h00, 8'h6B, 8'h00, 8'h03};
    row_s rows[10] = '{'{'0, REG_CTRL, '0, CTRL_RST, '0}, '{'0, REG_BAUD, '0, 32'h823, '0},
        '{'0, REG_STATUS, '0, '0, '0}, '{'0, REG_TXDATA, '0, '0, '0}, '{'0, 8'h20, '0, '0, '1},
        '{'1, 8'h20, 32'hFF, '0, '1}, '{'1, REG_BAUD, DIV, '0, '0}, '{'0, REG_BAUD, '0, DIV, '0},
        '{'1, REG_CTRL, 32'h601, '0, '0}, '{'0, REG_CTRL, '0, 32'h601, '0}};
    always #12.5 clk = ~clk;
    mbrtu_slave_framer i_mbrtu_slave_framer (
        .CORE_CLK(clk), .RST_N(rst_n), .CE(1'b1), .APB_REQ(req), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd), .TXD(txd), .TX_EN(tx_en));
    mbrtu_master_model i_mbrtu_master_model (
        .clk(clk), .div(16'(DIV)), .line_in(txd), .line_out(rxd));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d checks %0d", err_total, checks);
        if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        req <= '{a, 1'b1, 1'b0, w, d};
        @(posedge clk);
        req.penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1) begin
            err_total++;
            $display("FAIL %0t: no ready", $time);
        end
        rdata = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic query(input bytes_t m, input int mode);
        apb(1'b1, REG_STATUS, 32'h1F);
        i_mbrtu_master_model.send(m, mode);
        repeat (5 * CHAR) @(posedge clk);
        apb(1'b0, REG_STATUS, '0);
    endtask
    task automatic reply(input bytes_t exp);
        logic [15:0] c;
        int n = 0;
        i_mbrtu_master_model.rxq.delete();
        c = i_mbrtu_master_model.crc16(exp);
        if (exp.size() > 0) exp = {exp, c[7:0], c[15:8]};
        while (tx_en !== 1'b1 && ++n < 8 * CHAR) @(posedge clk);
        while (tx_en !== 1'b0 && ++n < 40 * CHAR) @(posedge clk);
        repeat (DIV) @(posedge clk);
        chk(32'(i_mbrtu_master_model.rxq.size()), 32'(exp.size()));
        foreach (exp[i]) chk({24'h0, i_mbrtu_master_model.rxq[i]}, {24'h0, exp[i]});
    endtask
    initial begin
        repeat (40000) @(posedge clk);
        err_total++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({31'h0, rerr}, {31'h0, rows[i].e});
            if (!rows[i].w) chk(rdata, rows[i].x);
        end
        query(q1, 0);
        chk(rdata, 32'h81);
        apb(1'b0, REG_QHEAD, '0);
        chk(rdata & 32'hFFFFFF, 32'h080306);
        apb(1'b0, REG_QFIELD, '0);
        chk(rdata, 32'h006B0003);
        apb(1'b1, REG_TXDATA, 32'h022B);
        apb(1'b1, REG_TXDATA, 32'h0);
        apb(1'b1, REG_TXDATA, 32'h0062);
        apb(1'b1, REG_TXCTRL, 32'h5);
        reply('{8'h06, 8'h03, 8'h06, 8'h02, 8'h2B, 8'h00, 8'h00, 8'h00, 8'h62});
        query('{8'h06, 8'h01, 8'h00, 8'h76, 8'h00, 8'h08}, 0);
        apb(1'b1, REG_TXCTRL, {16'h0, EXC_ILL_ADDR, 8'h03});
        reply('{8'h06, 8'h81, 8'h02});
        query('{8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
        chk(rdata & 32'h8, 32'h8);
        apb(1'b1, REG_TXCTRL, 32'h1);
        reply('{});
        query(q1, 1);
        chk(rdata & 32'h3, 32'h2);
        apb(1'b1, REG_TXCTRL, 32'h1);
        reply('{});
        i_mbrtu_master_model.send(q1, 0);
        query(q1, 0);
        chk(rdata & 32'h3, 32'h2);
        i_mbrtu_master_model.send('{8'h06, 8'h03}, 2);
        repeat (2 * CHAR) @(posedge clk);
        query(q1, 0);
        chk(rdata & 32'h3, 32'h1);
        chk({31'h0, i_mbrtu_master_model.stop_bad}, '0);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, REG_CTRL, '0);
        chk(rdata, CTRL_RST);
        stop_test;
    end
endmodule
